// *** logic/pcf_port_c_mux.sv ***
//----------------------------------------------------------------------
// pcf_port_c_mux
//----------------------------------------------------------------------
// Purpose: routes the sixteen port c pins to their peripheral functions
// Assumes: zero-wait apb slave, pins sampled through three flops
// Notes:   pad controls and peripheral inputs all come from flops
// Contract
// RQ1: single-function pin follows its owner enable
// RQ2: reserved select bits read zero, ignore writes
// RQ3: pin7 picks slave select or uart0 transmit
// RQ4: pin6 picks timer a2, crossbar3, comparator reference
// RQ5: pin5 picks converter output or crossbar7
// RQ6: pin4 picks timer a1 or comparator b
// RQ7: pin3 picks timer a0, comparator a, uart0 receive
// RQ8: pin2 picks uart0 tx, timer b0, crossbar2, clock
// RQ9: pin0 picks crystal pad or external clock
// RQ10: pin15 picks two-wire0 clock or crossbar out1
// RQ11: pin14 picks two-wire0 data or crossbar out0
// RQ12: pin13 picks timer a3 or crossbar input6
// RQ13: pin12 picks can receive, two-wire1 data, uart1
// RQ14: pin11 picks can transmit or two-wire1 clock
// RQ15: pin10 picks spi master out, crossbar5, master in
// RQ16: pin9 picks spi shift clock or crossbar4
// RQ17: pin8 picks spi master in or uart0 receive
// RQ18: chosen function also sets the pad mode
// RQ19: write guard blocks selects, lock until reset
// RQ20: owner enable chooses port or peripheral drive
// RQ21: reset to zero, reserved codes leave pin open
`timescale 1ns/1ps

module pcf_port_c_mux
	import pcf_pkg::*;
(
	// clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       rst_b_i,
	// apb slave
	input  wire logic                       psel_i,
	input  wire logic                       penable_i,
	input  wire logic                       pwrite_i,
	input  wire logic [PCF_ADDR_W-1:0]      paddr_i,
	input  wire logic [31:0]                pwdata_i,
	output logic [31:0]                     prdata_o,
	output logic                            pready_o,
	output logic                            pslverr_o,
	// port's own gpio drive
	input  wire logic [15:0]                gpio_out_i,
	input  wire logic [15:0]                gpio_oe_i,
	// peripherals
	input  wire pcf_from_per_t              from_per_i,
	output pcf_to_per_t                     to_per_o,
	// pad cells
	input  wire logic [15:0]                pad_in_i,
	output logic [15:0]                     pad_out_o,
	output logic [15:0]                     pad_oe_o,
	output pcf_pad_mode_t [15:0]            pad_mode_o
);

	//------------------------------------------------------------------
	// helpers
	//------------------------------------------------------------------

	// true when the bus address names register index idx
	function automatic logic hit(input logic [PCF_ADDR_W-1:0] a,
		input logic [5:0] idx);
		return a == {idx, 2'b00};
	endfunction

	// push-pull bidirectional function
	function automatic pcf_pin_t f_io(input pcf_drv_t d);
		return '{mode: PCF_PAD_IO, o: d.o, oe: d.oe};
	endfunction

	// output-only function, always driving
	function automatic pcf_pin_t f_out(input logic o);
		return '{mode: PCF_PAD_OUT, o: o, oe: 1'b1};
	endfunction

	// open-drain: drive low when asked, otherwise float
	function automatic pcf_pin_t f_od(input logic low);
		return '{mode: PCF_PAD_OD, o: 1'b0, oe: low};
	endfunction

	// input-only, analog or unconnected pads never drive
	function automatic pcf_pin_t f_quiet(input pcf_pad_mode_t m);
		return '{mode: m, o: 1'b0, oe: 1'b0};
	endfunction

	// pin level when routed, idle level otherwise
	function automatic logic fed(input logic c, input logic v,
		input logic idle);
		return c ? v : idle;
	endfunction

	//------------------------------------------------------------------
	// state
	//------------------------------------------------------------------
	pcf_state_t    st_ff;          // all registers of the block
	pcf_state_t    nxt_st;         // next value of st_ff
	pcf_pin_t      pin [16];       // per-pin peripheral choice
	logic [15:0]   s0;             // low select register
	logic [15:0]   s1;             // high select register
	logic [15:0]   ow;             // peripheral ownership per pin
	logic [15:0]   pv;             // filtered pin level
	logic          wr;             // apb write in access phase
	logic          setup;          // apb setup phase
	logic          mapped;         // address names a register
	logic          sel_open;       // select and owner writes allowed

	assign s0 = st_ff.sel_lo;
	assign s1 = st_ff.sel_hi;
	assign ow = st_ff.owner;
	assign pv = st_ff.pin_val;
	assign wr = psel_i & penable_i & pwrite_i;
	assign setup = psel_i & ~penable_i;
	assign mapped = hit(paddr_i, PCF_IDX_SEL_LO)
		| hit(paddr_i, PCF_IDX_SEL_HI)
		| hit(paddr_i, PCF_IDX_GUARD)
		| hit(paddr_i, PCF_IDX_OWNER);
	assign sel_open = ~st_ff.guard_on;

	//------------------------------------------------------------------
	// outputs
	//------------------------------------------------------------------
	// zero-wait slave: read data is captured in the setup phase
	assign pready_o   = 1'b1;
	assign pslverr_o  = psel_i & penable_i & ~mapped;
	assign prdata_o   = st_ff.prdata;
	assign pad_out_o  = st_ff.pad_out;
	assign pad_oe_o   = st_ff.pad_oe;
	assign pad_mode_o = st_ff.pad_mode;
	assign to_per_o   = st_ff.to_per;

	//------------------------------------------------------------------
	// next-state logic
	//------------------------------------------------------------------
	always_comb
	begin
		nxt_st = st_ff;

		// pin filter: a level counts once stages two and three agree;
		// stage one is seen only by stage two
		nxt_st.sync1 = pad_in_i;
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.sync3 = st_ff.sync2;
		nxt_st.pin_val = (st_ff.sync2 & st_ff.sync3)
			| (st_ff.pin_val & (st_ff.sync2 | st_ff.sync3));

		// register writes, taken at the access edge
		if (wr && sel_open && hit(paddr_i, PCF_IDX_SEL_LO))
		begin
			nxt_st.sel_lo = pwdata_i[15:0] & PCF_SEL_LO_MSK; // [RQ2] [RQ19]
		end
		if (wr && sel_open && hit(paddr_i, PCF_IDX_SEL_HI))
		begin
			nxt_st.sel_hi = pwdata_i[15:0] & PCF_SEL_HI_MSK; // [RQ2] [RQ19]
		end
		// ownership enables sit under the same guard
		if (wr && sel_open && hit(paddr_i, PCF_IDX_OWNER))
		begin
			nxt_st.owner = pwdata_i[15:0]; // [RQ19]
		end
		// once locked, the guard only changes at reset
		if (wr && !st_ff.guard_lock && hit(paddr_i, PCF_IDX_GUARD))
		begin
			nxt_st.guard_on   = pwdata_i[PCF_GUARD_ON];   // [RQ19]
			nxt_st.guard_lock = pwdata_i[PCF_GUARD_LOCK]; // [RQ19]
		end

		// read data, captured in setup so it stands during access
		if (setup)
		begin
			nxt_st.prdata = '0;
			if (hit(paddr_i, PCF_IDX_SEL_LO))
			begin
				nxt_st.prdata[15:0] = st_ff.sel_lo; // [RQ2]
			end
			else if (hit(paddr_i, PCF_IDX_SEL_HI))
			begin
				nxt_st.prdata[15:0] = st_ff.sel_hi; // [RQ2]
			end
			else if (hit(paddr_i, PCF_IDX_GUARD))
			begin
				nxt_st.prdata[PCF_GUARD_ON]   = st_ff.guard_on;
				nxt_st.prdata[PCF_GUARD_LOCK] = st_ff.guard_lock;
			end
			else if (hit(paddr_i, PCF_IDX_OWNER))
			begin
				nxt_st.prdata[15:0] = st_ff.owner;
			end
		end

		// pad side of each function; reserved codes stay quiet
		pin[0] = s0[PCF_C0] ? f_quiet(PCF_PAD_IN)
			: f_quiet(PCF_PAD_AN);                       // [RQ9] [RQ18]
		pin[1] = f_io(from_per_i.single_function);       // [RQ1]
		case (s0[PCF_C2 +: 2])                           // [RQ8]
			2'b00:   pin[2] = f_io(from_per_i.uart0_transmit);
			2'b01:   pin[2] = f_io(from_per_i.timer_b_channel_zero);
			2'b10:   pin[2] = f_quiet(PCF_PAD_IN);
			default: pin[2] = f_out(from_per_i.system_clock_output);
		endcase
		case (s0[PCF_C3 +: 2])                           // [RQ7]
			2'b00:   pin[3] = f_io(from_per_i.timer_a_channel[0]);
			2'b01:   pin[3] = f_out(from_per_i.comparator_a_output);
			2'b10:   pin[3] = f_quiet(PCF_PAD_IN);
			default: pin[3] = f_quiet(PCF_PAD_NONE);     // [RQ21]
		endcase
		pin[4] = s0[PCF_C4] ? f_out(from_per_i.comparator_b_output)
			: f_io(from_per_i.timer_a_channel[1]);       // [RQ6]
		pin[5] = s0[PCF_C5] ? f_quiet(PCF_PAD_IN)
			: f_quiet(PCF_PAD_AN);                       // [RQ5] [RQ18]
		case (s0[PCF_C6 +: 2])                           // [RQ4]
			2'b00:   pin[6] = f_io(from_per_i.timer_a_channel[2]);
			2'b01:   pin[6] = f_quiet(PCF_PAD_IN);
			2'b10:   pin[6] = f_quiet(PCF_PAD_AN);       // [RQ18]
			default: pin[6] = f_quiet(PCF_PAD_NONE);     // [RQ21]
		endcase
		pin[7] = s0[PCF_C7] ? f_io(from_per_i.uart0_transmit)
			: f_io(from_per_i.spi_port0_slave_select);   // [RQ3]
		pin[8] = s1[PCF_C8] ? f_quiet(PCF_PAD_IN)
			: f_io(from_per_i.spi_port0_master_in);      // [RQ17]
		pin[9] = s1[PCF_C9] ? f_quiet(PCF_PAD_IN)
			: f_io(from_per_i.spi_port0_shift_clock);    // [RQ16]
		case (s1[PCF_C10 +: 2])                          // [RQ15]
			2'b00:   pin[10] = f_io(from_per_i.spi_port0_master_out);
			2'b01:   pin[10] = f_quiet(PCF_PAD_IN);
			2'b10:   pin[10] = f_io(from_per_i.spi_port0_master_in);
			default: pin[10] = f_quiet(PCF_PAD_NONE);    // [RQ21]
		endcase
		case (s1[PCF_C11 +: 2])                          // [RQ14]
			2'b00:   pin[11] = f_od(from_per_i.can0_transmit);
			2'b01:   pin[11] = f_od(from_per_i.two_wire1_clock_low);
			default: pin[11] = f_quiet(PCF_PAD_NONE);    // [RQ21]
		endcase
		case (s1[PCF_C12 +: 2])                          // [RQ13]
			2'b00:   pin[12] = f_quiet(PCF_PAD_IN);
			2'b01:   pin[12] = f_od(from_per_i.two_wire1_data_low);
			2'b10:   pin[12] = f_quiet(PCF_PAD_IN);
			default: pin[12] = f_quiet(PCF_PAD_NONE);    // [RQ21]
		endcase
		pin[13] = s1[PCF_C13] ? f_quiet(PCF_PAD_IN)
			: f_io(from_per_i.timer_a_channel[3]);       // [RQ12]
		pin[14] = s1[PCF_C14] ? f_out(from_per_i.crossbar_output[0])
			: f_od(from_per_i.two_wire0_data_low);       // [RQ11] [RQ18]
		pin[15] = s1[PCF_C15] ? f_out(from_per_i.crossbar_output[1])
			: f_od(from_per_i.two_wire0_clock_low);      // [RQ10] [RQ18]

		// owner enable hands the pad to the peripheral or the port
		for (int i = 0; i < 16; i++)
		begin
			if (ow[i])
			begin
				nxt_st.pad_out[i]  = pin[i].o;               // [RQ20]
				nxt_st.pad_oe[i]   = pin[i].oe;              // [RQ18]
				nxt_st.pad_mode[i] = pin[i].mode;            // [RQ18]
			end
			else
			begin
				nxt_st.pad_out[i]  = gpio_out_i[i];          // [RQ20]
				nxt_st.pad_oe[i]   = gpio_oe_i[i];
				nxt_st.pad_mode[i] = PCF_PAD_IO;
			end
		end

		// pin levels to peripherals; an unrouted input rests at its
		// idle level so a serial receiver does not see a false start
		nxt_st.to_per.external_clock_input =
			fed(ow[0] && s0[PCF_C0], pv[0], 1'b0);           // [RQ9]
		nxt_st.to_per.single_function =
			fed(ow[1], pv[1], 1'b0);                         // [RQ1]
		nxt_st.to_per.timer_b_channel_zero =
			fed(ow[2] && s0[PCF_C2 +: 2] == 2'b01, pv[2], 1'b0); // [RQ8]
		nxt_st.to_per.crossbar_input[2] =
			fed(ow[2] && s0[PCF_C2 +: 2] == 2'b10, pv[2], 1'b0); // [RQ8]
		// uart0 transmit may sit on pin 2 or 7; pin 2 wins a clash
		nxt_st.to_per.uart0_transmit =
			fed(ow[2] && s0[PCF_C2 +: 2] == 2'b00, pv[2],
			fed(ow[7] && s0[PCF_C7], pv[7], 1'b1));          // [RQ3] [RQ8]
		nxt_st.to_per.timer_a_channel[0] =
			fed(ow[3] && s0[PCF_C3 +: 2] == 2'b00, pv[3], 1'b0); // [RQ7]
		// uart0 receive may sit on pin 3 or 8; pin 3 wins a clash
		nxt_st.to_per.uart0_receive =
			fed(ow[3] && s0[PCF_C3 +: 2] == 2'b10, pv[3],
			fed(ow[8] && s1[PCF_C8], pv[8], 1'b1));          // [RQ7] [RQ17]
		nxt_st.to_per.timer_a_channel[1] =
			fed(ow[4] && !s0[PCF_C4], pv[4], 1'b0);          // [RQ6]
		nxt_st.to_per.crossbar_input[7] =
			fed(ow[5] && s0[PCF_C5], pv[5], 1'b0);           // [RQ5]
		nxt_st.to_per.timer_a_channel[2] =
			fed(ow[6] && s0[PCF_C6 +: 2] == 2'b00, pv[6], 1'b0); // [RQ4]
		nxt_st.to_per.crossbar_input[3] =
			fed(ow[6] && s0[PCF_C6 +: 2] == 2'b01, pv[6], 1'b0); // [RQ4]
		nxt_st.to_per.spi_port0_slave_select =
			fed(ow[7] && !s0[PCF_C7], pv[7], 1'b1);          // [RQ3]
		// master in may sit on pin 8 or 10; pin 8 wins a clash
		nxt_st.to_per.spi_port0_master_in =
			fed(ow[8] && !s1[PCF_C8], pv[8],
			fed(ow[10] && s1[PCF_C10 +: 2] == 2'b10, pv[10], 1'b0));
		nxt_st.to_per.spi_port0_shift_clock =
			fed(ow[9] && !s1[PCF_C9], pv[9], 1'b0);          // [RQ16]
		nxt_st.to_per.crossbar_input[4] =
			fed(ow[9] && s1[PCF_C9], pv[9], 1'b0);           // [RQ16]
		nxt_st.to_per.spi_port0_master_out =
			fed(ow[10] && s1[PCF_C10 +: 2] == 2'b00, pv[10], 1'b0);
		nxt_st.to_per.crossbar_input[5] =
			fed(ow[10] && s1[PCF_C10 +: 2] == 2'b01, pv[10], 1'b0);
		nxt_st.to_per.two_wire1_clock =
			fed(ow[11] && s1[PCF_C11 +: 2] == 2'b01, pv[11], 1'b1);
		nxt_st.to_per.can0_receive =
			fed(ow[12] && s1[PCF_C12 +: 2] == 2'b00, pv[12], 1'b1);
		nxt_st.to_per.two_wire1_data =
			fed(ow[12] && s1[PCF_C12 +: 2] == 2'b01, pv[12], 1'b1);
		nxt_st.to_per.uart1_receive =
			fed(ow[12] && s1[PCF_C12 +: 2] == 2'b10, pv[12], 1'b1);
		nxt_st.to_per.timer_a_channel[3] =
			fed(ow[13] && !s1[PCF_C13], pv[13], 1'b0);       // [RQ12]
		nxt_st.to_per.crossbar_input[6] =
			fed(ow[13] && s1[PCF_C13], pv[13], 1'b0);        // [RQ12]
		nxt_st.to_per.two_wire0_data =
			fed(ow[14] && !s1[PCF_C14], pv[14], 1'b1);       // [RQ11]
		nxt_st.to_per.two_wire0_clock =
			fed(ow[15] && !s1[PCF_C15], pv[15], 1'b1);       // [RQ10]
	end

	//------------------------------------------------------------------
	// state register
	//------------------------------------------------------------------
	// synchronous reset; selects and owners start at zero
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			st_ff            <= '0;
			st_ff.sel_lo     <= PCF_SEL_RST;                 // [RQ21]
			st_ff.sel_hi     <= PCF_SEL_RST;                 // [RQ21]
			st_ff.owner      <= PCF_OWNER_RST;
			st_ff.guard_on   <= PCF_GUARD_RST[PCF_GUARD_ON]; // [RQ19]
			st_ff.guard_lock <= PCF_GUARD_RST[PCF_GUARD_LOCK];
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

endmodule

// *** logic/pcf_pkg.sv ***
//----------------------------------------------------------------------
// pcf_pkg
//----------------------------------------------------------------------
// Purpose: constants and carriers of the port c function select mux
// Assumes: apb with 32-bit data, word index times four is the address
// Notes:   select fields reset to zero, the first function of each pin
package pcf_pkg;

	// ---------------------------------------------------------------
	// register indices and apb geometry
	// ---------------------------------------------------------------
	localparam int unsigned   PCF_ADDR_W     = 8;
	localparam logic [5:0]    PCF_IDX_SEL_LO = 6'h15; // low pin select
	localparam logic [5:0]    PCF_IDX_SEL_HI = 6'h16; // high pin select
	localparam logic [5:0]    PCF_IDX_GUARD  = 6'h17; // write guard
	localparam logic [5:0]    PCF_IDX_OWNER  = 6'h18; // owner enables
	localparam logic [15:0]   PCF_SEL_LO_MSK = 16'h75f1; // writable bits
	localparam logic [15:0]   PCF_SEL_HI_MSK = 16'h57f5; // writable bits
	localparam logic [15:0]   PCF_SEL_RST    = 16'h0000;
	localparam logic [15:0]   PCF_OWNER_RST  = 16'h0000;
	localparam logic [1:0]    PCF_GUARD_RST  = 2'h0;  // off, unlocked
	localparam int unsigned   PCF_GUARD_ON   = 0;     // guard field bits
	localparam int unsigned   PCF_GUARD_LOCK = 1;

	// ---------------------------------------------------------------
	// select field positions
	// ---------------------------------------------------------------
	localparam int unsigned   PCF_C0  = 0;   // single bit, low reg
	localparam int unsigned   PCF_C2  = 4;   // two bits, lsb
	localparam int unsigned   PCF_C3  = 6;   // two bits, lsb
	localparam int unsigned   PCF_C4  = 8;
	localparam int unsigned   PCF_C5  = 10;
	localparam int unsigned   PCF_C6  = 12;  // two bits, lsb
	localparam int unsigned   PCF_C7  = 14;
	localparam int unsigned   PCF_C8  = 0;   // single bit, high reg
	localparam int unsigned   PCF_C9  = 2;
	localparam int unsigned   PCF_C10 = 4;   // two bits, lsb
	localparam int unsigned   PCF_C11 = 6;   // two bits, lsb
	localparam int unsigned   PCF_C12 = 8;   // two bits, lsb
	localparam int unsigned   PCF_C13 = 10;
	localparam int unsigned   PCF_C14 = 12;
	localparam int unsigned   PCF_C15 = 14;

	// ---------------------------------------------------------------
	// pad modes and carriers
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		PCF_PAD_NONE = 3'h0, // not connected to any function
		PCF_PAD_IN   = 3'h1, // digital input only
		PCF_PAD_IO   = 3'h2, // push-pull bidirectional
		PCF_PAD_OUT  = 3'h3, // digital output only
		PCF_PAD_OD   = 3'h6, // open-drain, oe means pull low
		PCF_PAD_AN   = 3'h7  // analog, digital buffers off
	} pcf_pad_mode_t;

	typedef struct packed {
		logic o;             // value driven
		logic oe;            // drive enable
	} pcf_drv_t;

	typedef struct packed {
		pcf_pad_mode_t mode;
		logic          o;
		logic          oe;
	} pcf_pin_t;

	// drives coming from the peripherals
	typedef struct packed {
		pcf_drv_t       spi_port0_slave_select;
		pcf_drv_t       uart0_transmit;
		pcf_drv_t [3:0] timer_a_channel;
		pcf_drv_t       timer_b_channel_zero;
		pcf_drv_t       spi_port0_master_out;
		pcf_drv_t       spi_port0_master_in;
		pcf_drv_t       spi_port0_shift_clock;
		pcf_drv_t       single_function;   // pin one, no field
		logic           comparator_a_output;
		logic           comparator_b_output;
		logic           system_clock_output;
		logic [1:0]     crossbar_output;
		logic           can0_transmit;
		logic           two_wire0_clock_low; // pull-low requests
		logic           two_wire0_data_low;
		logic           two_wire1_clock_low;
		logic           two_wire1_data_low;
	} pcf_from_per_t;

	// pin levels handed to the peripherals
	typedef struct packed {
		logic       spi_port0_slave_select;
		logic       uart0_transmit;
		logic       uart0_receive;
		logic       uart1_receive;
		logic [3:0] timer_a_channel;
		logic       timer_b_channel_zero;
		logic [7:2] crossbar_input;
		logic       external_clock_input;
		logic       two_wire0_clock;
		logic       two_wire0_data;
		logic       two_wire1_clock;
		logic       two_wire1_data;
		logic       can0_receive;
		logic       spi_port0_master_out;
		logic       spi_port0_master_in;
		logic       spi_port0_shift_clock;
		logic       single_function;
	} pcf_to_per_t;

	// whole state of the mux
	typedef struct packed {
		logic [15:0]               sel_lo;
		logic [15:0]               sel_hi;
		logic [15:0]               owner;
		logic                      guard_on;
		logic                      guard_lock;
		logic [15:0]               sync1;
		logic [15:0]               sync2;
		logic [15:0]               sync3;
		logic [15:0]               pin_val;
		logic [15:0]               pad_out;
		logic [15:0]               pad_oe;
		pcf_pad_mode_t [15:0]      pad_mode;
		pcf_to_per_t               to_per;
		logic [31:0]               prdata;
	} pcf_state_t;

endpackage

// *** sim/pcf_port_c_mux_monitor.sv ***
// Purpose: port-level checks of the port c function mux
// Assumes: zero-wait apb, pad outputs registered one edge
// Notes:   bound to every mux instance below
`timescale 1ns/1ps
module pcf_port_c_mux_monitor
	import pcf_pkg::*;
(
	// clock, reset and apb
	input wire logic                  clk_i,
	input wire logic                  rst_b_i,
	input wire logic                  psel_i,
	input wire logic                  penable_i,
	input wire logic                  pwrite_i,
	input wire logic [PCF_ADDR_W-1:0] paddr_i,
	input wire logic [31:0]           prdata_o,
	// peripherals and pads
	input wire pcf_from_per_t         from_per_i,
	input wire pcf_to_per_t           to_per_o,
	input wire logic [15:0]           pad_in_i,
	input wire logic [15:0]           pad_out_o,
	input wire logic [15:0]           pad_oe_o,
	input wire pcf_pad_mode_t [15:0]  pad_mode_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// read access phase, where prdata must already be valid
	wire rd = psel_i && penable_i && !pwrite_i;
	rst_clear_a: assert property (
		$rose(rst_b_i) |-> pad_oe_o == 16'h0 && to_per_o == '0)
		else $error("pads not idle after reset");
	lo_resv_a: assert property (
		rd && paddr_i == 8'h54 |-> (prdata_o & ~32'h75f1) == 32'h0)
		else $error("low select reserved bit set");
	hi_resv_a: assert property (
		rd && paddr_i == 8'h58 |-> (prdata_o & ~32'h57f5) == 32'h0)
		else $error("high select reserved bit set");
	crystal_amplifier_pad_an_a: assert property (
		pad_mode_o[0] == PCF_PAD_AN |-> !pad_oe_o[0])
		else $error("analog pin0 driven");
	scl_od_a: assert property (
		pad_mode_o[15] == PCF_PAD_OD |-> !pad_out_o[15] &&
		pad_oe_o[15] == $past(from_per_i.two_wire0_clock_low))
		else $error("pin15 open-drain drive wrong");
	cmpb_out_a: assert property (
		pad_mode_o[4] == PCF_PAD_OUT |-> pad_oe_o[4] &&
		pad_out_o[4] == $past(from_per_i.comparator_b_output))
		else $error("pin4 not driven by comparator b");
	system_clock_output_out_a: assert property (
		pad_mode_o[2] == PCF_PAD_OUT |-> pad_oe_o[2] &&
		pad_out_o[2] == $past(from_per_i.system_clock_output))
		else $error("pin2 not driven by clock output");
	xb4_in_a: assert property (
		(pad_mode_o[9] == PCF_PAD_IN && $stable(pad_in_i[9]))[*5]
		|-> to_per_o.crossbar_input[4] == pad_in_i[9])
		else $error("pin9 level not passed to crossbar");
endmodule
bind pcf_port_c_mux pcf_port_c_mux_monitor i_pcf_port_c_mux_monitor (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.prdata_o(prdata_o), .from_per_i(from_per_i), .to_per_o(to_per_o),
	.pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
	.pad_mode_o(pad_mode_o));

// *** sim/pcf_per_model.sv ***
// Purpose: peripherals and pad cells beside the port c mux
// Assumes: the bench gives the far-side level of each pin
// Notes:   open-drain pins show the far-side level unless pulled low
`timescale 1ns/1ps
module pcf_per_model
	import pcf_pkg::*;
(
	// clock and bench controls
	input  wire logic                 clk_i,
	input  wire pcf_from_per_t        drv_i,
	input  wire logic [15:0]          ext_i,
	// mux side
	input  wire logic [15:0]          pad_out_i,
	input  wire logic [15:0]          pad_oe_i,
	input  wire pcf_pad_mode_t [15:0] pad_mode_i,
	output pcf_from_per_t             from_per_o,
	output logic [15:0]               pad_in_o
);
	// peripherals launch their drives from flops
	always_ff @(posedge clk_i)
		from_per_o <= drv_i;
	// the mux wins where it drives; a released pin shows the far side
	always_comb
	begin
		for (int i = 0; i < 16; i++)
		begin
			if (pad_mode_i[i] == PCF_PAD_OD)
				pad_in_o[i] = ext_i[i] & !pad_oe_i[i];
			else if (pad_oe_i[i])
				pad_in_o[i] = pad_out_i[i];
			else
				pad_in_o[i] = ext_i[i];
		end
	end
endmodule

// *** sim/pcf_port_c_mux_test.sv ***
// Purpose: self-checking bench of the port c function mux
// Assumes: 100 MHz clock, the bench is the apb master
// Notes:   a reset clears the guard lock at the end of the run
`timescale 1ns/1ps
module pcf_port_c_mux_test import pcf_pkg::*;;
	logic clk_i = 1'b0, rst_b_i = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic pready, pslverr;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [15:0] gpio_out = 16'h0, gpio_oe = 16'h0, ext = 16'h0;
	logic [15:0] pad_in, pad_out, pad_oe;
	pcf_pad_mode_t [15:0] pad_mode;
	pcf_from_per_t drv = '0, from_per;
	pcf_to_per_t to_per;
	int err_count = 0, checks = 0;
	// addr, data, pin, expected pad mode
	localparam logic [30:0] TBL [15] = '{
		{8'h54, 16'h0000, 4'd0, PCF_PAD_AN},
		{8'h54, 16'h0001, 4'd0, PCF_PAD_IN},
		{8'h54, 16'h0030, 4'd2, PCF_PAD_OUT},
		{8'h54, 16'h0080, 4'd3, PCF_PAD_IN},
		{8'h54, 16'h00c0, 4'd3, PCF_PAD_NONE},
		{8'h54, 16'h0400, 4'd5, PCF_PAD_IN},
		{8'h54, 16'h2000, 4'd6, PCF_PAD_AN},
		{8'h54, 16'h4000, 4'd7, PCF_PAD_IO},
		{8'h58, 16'h0000, 4'd15, PCF_PAD_OD},
		{8'h58, 16'h1000, 4'd14, PCF_PAD_OUT},
		{8'h58, 16'h0400, 4'd13, PCF_PAD_IN},
		{8'h58, 16'h0300, 4'd12, PCF_PAD_NONE},
		{8'h58, 16'h0040, 4'd11, PCF_PAD_OD},
		{8'h58, 16'h0020, 4'd10, PCF_PAD_IO},
		{8'h58, 16'h0001, 4'd8, PCF_PAD_IN}};
	always #5 clk_i = ~clk_i;
	pcf_port_c_mux i_pcf_port_c_mux (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .gpio_out_i(gpio_out),
		.gpio_oe_i(gpio_oe), .from_per_i(from_per), .to_per_o(to_per),
		.pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
		.pad_mode_o(pad_mode));
	pcf_per_model i_pcf_per_model (.clk_i(clk_i), .drv_i(drv),
		.ext_i(ext), .pad_out_i(pad_out), .pad_oe_i(pad_oe),
		.pad_mode_i(pad_mode), .from_per_o(from_per), .pad_in_o(pad_in));
	task automatic check(input string nm, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp)
		begin
			$display("BAD %s expected %h seen %h", nm, exp, seen);
			err_count++;
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// one apb transfer; the wait for pready is bounded
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		@(posedge clk_i);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk_i);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			err_count++;
			results();
		end
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input string nm, input logic [7:0] a,
		input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		check(nm, q, exp);
	endtask
	// reset values, reserved bits, an unmapped address
	task automatic t_regs();
		logic [31:0] q;
		logic e;
		rd("lo reset", 8'h54, 32'h0);
		rd("hi reset", 8'h58, 32'h0);
		wr(8'h54, 32'hffff_ffff);
		rd("lo mask", 8'h54, 32'h75f1);
		wr(8'h58, 32'hffff_ffff);
		rd("hi mask", 8'h58, 32'h57f5);
		apb(1'b0, 8'h40, 32'h0, q, e);
		check("unmapped", {e, q[30:0]}, 32'h8000_0000);
	endtask
	// fifteen select codes against their pad modes, then both data paths
	task automatic t_route();
		logic [30:0] t;
		wr(8'h60, 32'hffff);
		foreach (TBL[k])
		begin
			t = TBL[k];
			wr(t[30:23], 32'(t[22:7]));
			cyc(2);
			check("mode", 32'(pad_mode[t[6:3]]), 32'(t[2:0]));
		end
		drv.comparator_b_output <= 1'b1;
		drv.system_clock_output <= 1'b1;
		ext[9] <= 1'b1;
		wr(8'h54, 32'h0130);
		wr(8'h58, 32'h0004);
		cyc(6);
		check("pin4", {pad_oe[4], pad_out[4]}, 32'h3);
		check("pin2", {pad_oe[2], pad_out[2]}, 32'h3);
		check("xbar4", to_per.crossbar_input[4], 32'h1);
	endtask
	// single-function pin follows its owner bit
	task automatic t_owner();
		drv.single_function <= 2'b11;
		gpio_oe <= 16'h0002;
		// model flop, pad flop, three sync stages, filter, to_per flop
		cyc(8);
		check("pin1 per", pad_out[1], 32'h1);
		check("pin1 in", to_per.single_function, 32'h1);
		wr(8'h60, 32'hfffd);
		cyc(2);
		check("pin1 gpio", {pad_oe[1], pad_out[1]}, 32'h2);
	endtask
	// guard blocks writes; a locked guard holds until reset
	task automatic t_guard();
		wr(8'h54, 32'h0100);
		wr(8'h5c, 32'h1);
		wr(8'h54, 32'h0001);
		rd("guarded", 8'h54, 32'h0100);
		wr(8'h5c, 32'h0);
		wr(8'h54, 32'h0001);
		rd("unguarded", 8'h54, 32'h0001);
		wr(8'h5c, 32'h3);
		wr(8'h5c, 32'h0);
		rd("locked", 8'h5c, 32'h3);
		// only a reset may release the lock
		rst_b_i <= 1'b0;
		cyc(2);
		rst_b_i <= 1'b1;
		rd("unlocked", 8'h5c, 32'h0);
	endtask
	initial
	begin
		cyc(2);
		rst_b_i <= 1'b1;
		t_regs();
		t_route();
		t_owner();
		t_guard();
		results();
	end
endmodule
